/* light_prox_pkg.sv */
package light_prox_pkg;
	// register offsets
	localparam logic [7:0] LIGHT_RESULT_LOW_ADDR = 8'h03;
	localparam logic [7:0] LIGHT_RESULT_HIGH_ADDR = 8'h04;
	localparam logic [7:0] LIGHT_UPPER_LIMIT_LOW_ADDR = 8'h05;
	localparam logic [7:0] LIGHT_UPPER_LIMIT_HIGH_ADDR = 8'h06;
	localparam logic [7:0] LIGHT_LOWER_LIMIT_LOW_ADDR = 8'h07;
	localparam logic [7:0] LIGHT_LOWER_LIMIT_HIGH_ADDR = 8'h08;
	localparam logic [7:0] PROXIMITY_CONTROL_ADDR = 8'h09;
	localparam logic [7:0] PROX_OFFSET_ADDR = 8'hA5;
	// reset values
	localparam logic [7:0] PROXIMITY_CONTROL_RESET = 8'h00;
	localparam logic [15:0] LIGHT_UPPER_LIMIT_RESET = 16'hFFFF;
	localparam logic [15:0] LIGHT_LOWER_LIMIT_RESET = 16'h0000;
	localparam logic [15:0] LIGHT_RESULT_RESET = 16'h0000;
	// proximity control field positions
	localparam int OFFSET_CALIBRATE_BIT = 7;
	localparam int EMITTER_PULSE_WIDTH_LSB = 4;
	localparam int EMITTER_DRIVE_LEVEL_LSB = 2;
	localparam int PROXIMITY_PERSIST_LSB = 0;
	// manual-scaling result width
	localparam int MANUAL_RESULT_BITS = 12;
	// emitter drive base currents in microamps, codes 00..11
	localparam logic [13:0] DRIVE_UA_0 = 14'h09C4;
	localparam logic [13:0] DRIVE_UA_1 = 14'h1388;
	localparam logic [13:0] DRIVE_UA_2 = 14'h2710;
	localparam logic [13:0] DRIVE_UA_3 = 14'h3A98;
	// magnification codes
	localparam logic [3:0] MAG_X1_CODE = 4'h0;
	localparam logic [3:0] MAG_X2_CODE = 4'h8;
	localparam logic [3:0] MAG_X10_CODE = 4'h5;
	localparam logic [3:0] MAG_X20_CODE = 4'hD;
	// timing
	localparam int CLK_PERIOD_PS = 5000;
	localparam int PULSE_BASE_NS = 50000;
	localparam int PULSE_BASE_CYCLES = (PULSE_BASE_NS * 1000) / CLK_PERIOD_PS;
	// arbitrary bus address of the device
	localparam logic [6:0] DEVICE_BUS_ADDR = 7'h38;
	// serial slave states
	typedef enum logic [6:0] {
		ST_IDLE = 7'b0000001,
		ST_ADDR = 7'b0000010,
		ST_ADDR_ACK = 7'b0000100,
		ST_WR = 7'b0001000,
		ST_WR_ACK = 7'b0010000,
		ST_RD = 7'b0100000,
		ST_RD_ACK = 7'b1000000
	} slave_state_t;
endpackage

/* light_prox_threshold_regs.sv */
`timescale 1ns/1ps
// What this block does
// - with manual scaling the light result is a 12-bit value in bits 11 to 0 across the result register pair.
// - with automatic scaling the light result is a full 16-bit value in bits 15 to 0.
// - a light interrupt is raised when results above the high limit reach the persist count.
// - a light interrupt is raised when results below the low limit reach the persist count.
// - with automatic scaling both light limits are compared as full 16-bit values.
// - setting the calibrate bit with proximity enabled starts an offset measurement whose result is written to 0xA5.
// - the 3-bit pulse width field sets a pulse of 0.05 ms times two to the power of the code.
// - the proximity persist field needs 1, 2, 3 or 4 consecutive out-of-range results.
// - the light persist field needs 1, 2, 4 or 8 consecutive out-of-range results.
// - auto scale bit high means manual scaling with programmed settings, low means automatic scaling.
module light_prox_threshold_regs #(
	parameter logic [6:0] DEV_ADDR = light_prox_pkg::DEVICE_BUS_ADDR, // arbitrary default
	parameter int PULSE_BASE_CYCLES = light_prox_pkg::PULSE_BASE_CYCLES
) (
	input wire logic core_clk, // 200 MHz clock
	input wire logic reset, // async, active high
	input wire logic clk_en, // freezes all state when low
	input wire logic scl_in, // serial clock pin
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // serial data drive value
	output logic sda_oe_n, // low while driving data low
	input wire logic auto_scale, // 1 manual, 0 automatic
	input wire logic [1:0] light_persist, // light persist code
	input wire logic light_valid, // new light result pulse
	input wire logic [15:0] light_data, // light converter output
	output logic light_int, // light threshold interrupt
	input wire logic light_int_clear, // clears light_int
	input wire logic prox_enable, // proximity sensing enabled
	input wire logic prox_valid, // new proximity result pulse
	input wire logic [7:0] prox_data, // proximity result
	input wire logic [7:0] prox_high_limit, // proximity high threshold
	input wire logic [7:0] prox_low_limit, // proximity low threshold
	output logic prox_int, // proximity threshold interrupt
	input wire logic prox_int_clear, // clears prox_int
	output logic offset_cal_start, // starts offset measurement
	input wire logic offset_cal_done, // measurement finished pulse
	input wire logic [7:0] offset_cal_value, // measured offset
	output logic offset_wr_en, // write pulse to offset register
	output logic [7:0] offset_wr_addr, // offset register address
	output logic [7:0] offset_wr_data, // offset value written
	input wire logic emitter_fire, // request one emitter pulse
	output logic emitter_on, // emitter drive active
	input wire logic [3:0] drive_magnify, // magnification code
	output logic [18:0] emitter_current_ua // drive current in microamps
);
	light_prox_pkg::slave_state_t state_reg;
	logic [2:0] scl_sync, sda_sync;
	logic scl_f, sda_f, scl_prev, sda_prev;
	logic [7:0] shift_reg, ptr_reg;
	logic [2:0] bit_cnt;
	logic byte_done, got_ptr, nack_reg, drive_low;
	logic [15:0] result_reg, upper_reg, lower_reg;
	logic [7:0] control_reg;
	logic [3:0] light_cnt;
	logic [2:0] prox_cnt;
	logic cal_busy;
	logic [20:0] pulse_cnt;
	logic scl_rise, scl_fall, start_seen, stop_seen;
	logic wr_commit, ctrl_written;
	logic [7:0] rd_byte;
	logic [15:0] light_cmp, upper_cmp, lower_cmp;
	logic light_out, prox_out;
	logic [3:0] light_need;
	logic [2:0] prox_need;
	logic [13:0] base_ua;
	logic [4:0] mag;

	// three-stage pin synchronisers
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			scl_sync <= 3'h7;
			sda_sync <= 3'h7;
		end
		else if (clk_en)
		begin
			scl_sync <= {scl_sync[1:0], scl_in};
			sda_sync <= {sda_sync[1:0], sda_in};
		end
	end

	// filtered levels change once stages two and three agree
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			scl_f <= 1'b1;
			sda_f <= 1'b1;
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end
		else if (clk_en)
		begin
			if (scl_sync[1] == scl_sync[2])
				scl_f <= scl_sync[2];
			if (sda_sync[1] == sda_sync[2])
				sda_f <= sda_sync[2];
			scl_prev <= scl_f;
			sda_prev <= sda_f;
		end
	end

	// bus events
	assign scl_rise = scl_f & ~scl_prev;
	assign scl_fall = ~scl_f & scl_prev;
	assign start_seen = scl_f & scl_prev & sda_prev & ~sda_f;
	assign stop_seen = scl_f & scl_prev & ~sda_prev & sda_f;
	assign wr_commit = scl_fall && (state_reg == light_prox_pkg::ST_WR) && byte_done && got_ptr;
	assign ctrl_written = wr_commit && (ptr_reg == light_prox_pkg::PROXIMITY_CONTROL_ADDR);

	// register read mux, low byte at lower address
	always_comb
	begin
		case (ptr_reg)
			light_prox_pkg::LIGHT_RESULT_LOW_ADDR: rd_byte = result_reg[7:0];
			light_prox_pkg::LIGHT_RESULT_HIGH_ADDR: rd_byte = result_reg[15:8];
			light_prox_pkg::LIGHT_UPPER_LIMIT_LOW_ADDR: rd_byte = upper_reg[7:0];
			light_prox_pkg::LIGHT_UPPER_LIMIT_HIGH_ADDR: rd_byte = upper_reg[15:8];
			light_prox_pkg::LIGHT_LOWER_LIMIT_LOW_ADDR: rd_byte = lower_reg[7:0];
			light_prox_pkg::LIGHT_LOWER_LIMIT_HIGH_ADDR: rd_byte = lower_reg[15:8];
			light_prox_pkg::PROXIMITY_CONTROL_ADDR: rd_byte = control_reg;
			default: rd_byte = 8'h00;
		endcase
	end

	// serial slave sequencing
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			state_reg <= light_prox_pkg::ST_IDLE;
			shift_reg <= 8'h00;
			ptr_reg <= 8'h00;
			bit_cnt <= 3'h0;
			byte_done <= 1'b0;
			got_ptr <= 1'b0;
			nack_reg <= 1'b0;
			drive_low <= 1'b0;
		end
		else if (clk_en)
		begin
			if (start_seen)
			begin
				state_reg <= light_prox_pkg::ST_ADDR;
				bit_cnt <= 3'h0;
				byte_done <= 1'b0;
				got_ptr <= 1'b0;
				drive_low <= 1'b0;
			end
			else if (stop_seen)
			begin
				state_reg <= light_prox_pkg::ST_IDLE;
				drive_low <= 1'b0;
			end
			else if (scl_rise)
			begin
				case (state_reg)
					light_prox_pkg::ST_ADDR, light_prox_pkg::ST_WR:
					begin
						shift_reg <= {shift_reg[6:0], sda_f};
						bit_cnt <= bit_cnt + 3'h1;
						byte_done <= (bit_cnt == 3'h7);
					end
					light_prox_pkg::ST_RD:
					begin
						bit_cnt <= bit_cnt + 3'h1;
						byte_done <= (bit_cnt == 3'h7);
					end
					light_prox_pkg::ST_RD_ACK: nack_reg <= sda_f;
					default: nack_reg <= nack_reg;
				endcase
			end
			else if (scl_fall)
			begin
				case (state_reg)
					light_prox_pkg::ST_ADDR:
					begin
						if (byte_done)
						begin
							byte_done <= 1'b0;
							if (shift_reg[7:1] == DEV_ADDR)
							begin
								state_reg <= light_prox_pkg::ST_ADDR_ACK;
								drive_low <= 1'b1;
							end
							else
								state_reg <= light_prox_pkg::ST_IDLE;
						end
					end
					light_prox_pkg::ST_ADDR_ACK:
					begin
						bit_cnt <= 3'h0;
						if (shift_reg[0])
						begin
							state_reg <= light_prox_pkg::ST_RD;
							shift_reg <= rd_byte;
							drive_low <= ~rd_byte[7];
						end
						else
						begin
							state_reg <= light_prox_pkg::ST_WR;
							drive_low <= 1'b0;
						end
					end
					light_prox_pkg::ST_WR:
					begin
						if (byte_done)
						begin
							byte_done <= 1'b0;
							state_reg <= light_prox_pkg::ST_WR_ACK;
							drive_low <= 1'b1;
							got_ptr <= 1'b1;
							// first byte sets the pointer, later bytes auto-increment it
							if (!got_ptr)
								ptr_reg <= shift_reg;
							else
								ptr_reg <= ptr_reg + 8'h01;
						end
					end
					light_prox_pkg::ST_WR_ACK:
					begin
						state_reg <= light_prox_pkg::ST_WR;
						drive_low <= 1'b0;
						bit_cnt <= 3'h0;
					end
					light_prox_pkg::ST_RD:
					begin
						if (byte_done)
						begin
							byte_done <= 1'b0;
							state_reg <= light_prox_pkg::ST_RD_ACK;
							drive_low <= 1'b0;
							ptr_reg <= ptr_reg + 8'h01;
						end
						else
						begin
							shift_reg <= {shift_reg[6:0], 1'b0};
							drive_low <= ~shift_reg[6];
						end
					end
					light_prox_pkg::ST_RD_ACK:
					begin
						bit_cnt <= 3'h0;
						if (nack_reg)
							state_reg <= light_prox_pkg::ST_IDLE;
						else
						begin
							state_reg <= light_prox_pkg::ST_RD;
							shift_reg <= rd_byte;
							drive_low <= ~rd_byte[7];
						end
					end
					default: state_reg <= light_prox_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// open-drain data pin, only ever pulled low
	assign sda_out = 1'b0;
	assign sda_oe_n = ~drive_low;

	// host-writable limit registers; result bytes are read only
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			upper_reg <= light_prox_pkg::LIGHT_UPPER_LIMIT_RESET;
			lower_reg <= light_prox_pkg::LIGHT_LOWER_LIMIT_RESET;
		end
		else if (clk_en && wr_commit)
		begin
			case (ptr_reg)
				light_prox_pkg::LIGHT_UPPER_LIMIT_LOW_ADDR: upper_reg[7:0] <= shift_reg;
				light_prox_pkg::LIGHT_UPPER_LIMIT_HIGH_ADDR: upper_reg[15:8] <= shift_reg;
				light_prox_pkg::LIGHT_LOWER_LIMIT_LOW_ADDR: lower_reg[7:0] <= shift_reg;
				light_prox_pkg::LIGHT_LOWER_LIMIT_HIGH_ADDR: lower_reg[15:8] <= shift_reg;
				default: upper_reg <= upper_reg;
			endcase
		end
	end

	// proximity control; calibrate bit self-clears when the measurement ends
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			control_reg <= light_prox_pkg::PROXIMITY_CONTROL_RESET;
		else if (clk_en)
		begin
			if (ctrl_written)
				control_reg <= shift_reg;
			else if (offset_cal_done && cal_busy)
				control_reg[light_prox_pkg::OFFSET_CALIBRATE_BIT] <= 1'b0;
		end
	end

	// offset measurement start and automatic write of its result
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			cal_busy <= 1'b0;
			offset_cal_start <= 1'b0;
			offset_wr_en <= 1'b0;
			offset_wr_addr <= 8'h00;
			offset_wr_data <= 8'h00;
		end
		else if (clk_en)
		begin
			offset_cal_start <= 1'b0;
			offset_wr_en <= 1'b0;
			if (cal_busy && offset_cal_done)
			begin
				cal_busy <= 1'b0;
				offset_wr_en <= 1'b1;
				offset_wr_addr <= light_prox_pkg::PROX_OFFSET_ADDR;
				offset_wr_data <= offset_cal_value;
			end
			else if (!cal_busy && prox_enable && control_reg[light_prox_pkg::OFFSET_CALIBRATE_BIT])
			begin
				cal_busy <= 1'b1;
				offset_cal_start <= 1'b1;
			end
		end
	end

	// light comparison width follows the scaling mode
	assign light_cmp = auto_scale ? {4'h0, light_data[11:0]} : light_data;
	assign upper_cmp = auto_scale ? {4'h0, upper_reg[11:0]} : upper_reg;
	assign lower_cmp = auto_scale ? {4'h0, lower_reg[11:0]} : lower_reg;
	assign light_out = (light_cmp > upper_cmp) || (light_cmp < lower_cmp);
	assign light_need = 4'h1 << light_persist;
	assign prox_out = (prox_data > prox_high_limit) || (prox_data < prox_low_limit);
	assign prox_need = {1'b0, control_reg[light_prox_pkg::PROXIMITY_PERSIST_LSB +: 2]} + 3'h1;

	// light result capture and persist filter
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			result_reg <= light_prox_pkg::LIGHT_RESULT_RESET;
			light_cnt <= 4'h0;
			light_int <= 1'b0;
		end
		else if (clk_en)
		begin
			if (light_valid)
			begin
				result_reg <= light_cmp;
				if (light_out)
					light_cnt <= (light_cnt == 4'hF) ? light_cnt : light_cnt + 4'h1;
				else
					light_cnt <= 4'h0;
			end
			// a new trigger wins over a clear in the same cycle; widened so a saturated count still fires
			if (light_valid && light_out && ({1'b0, light_cnt} + 5'h01 >= {1'b0, light_need}))
				light_int <= 1'b1;
			else if (light_int_clear)
				light_int <= 1'b0;
		end
	end

	// proximity persist filter
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			prox_cnt <= 3'h0;
			prox_int <= 1'b0;
		end
		else if (clk_en)
		begin
			if (prox_valid)
			begin
				if (prox_out)
					prox_cnt <= (prox_cnt == 3'h7) ? prox_cnt : prox_cnt + 3'h1;
				else
					prox_cnt <= 3'h0;
			end
			if (prox_valid && prox_out && ({1'b0, prox_cnt} + 4'h1 >= {1'b0, prox_need}))
				prox_int <= 1'b1;
			else if (prox_int_clear)
				prox_int <= 1'b0;
		end
	end

	// emitter pulse timer, length is base times two to the code
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			pulse_cnt <= 21'h000000;
			emitter_on <= 1'b0;
		end
		else if (clk_en)
		begin
			if (emitter_on)
			begin
				if (pulse_cnt == 21'h000001)
					emitter_on <= 1'b0;
				pulse_cnt <= pulse_cnt - 21'h000001;
			end
			else if (emitter_fire)
			begin
				emitter_on <= 1'b1;
				pulse_cnt <= 21'(PULSE_BASE_CYCLES) << control_reg[light_prox_pkg::EMITTER_PULSE_WIDTH_LSB +: 3];
			end
		end
	end

	// drive current tables
	always_comb
	begin
		case (control_reg[light_prox_pkg::EMITTER_DRIVE_LEVEL_LSB +: 2])
			2'h0: base_ua = light_prox_pkg::DRIVE_UA_0;
			2'h1: base_ua = light_prox_pkg::DRIVE_UA_1;
			2'h2: base_ua = light_prox_pkg::DRIVE_UA_2;
			default: base_ua = light_prox_pkg::DRIVE_UA_3;
		endcase
		case (drive_magnify)
			light_prox_pkg::MAG_X2_CODE: mag = 5'h02;
			light_prox_pkg::MAG_X10_CODE: mag = 5'h0A;
			light_prox_pkg::MAG_X20_CODE: mag = 5'h14;
			default: mag = 5'h01;
		endcase
	end

	// registered drive current
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			emitter_current_ua <= 19'h00000;
		else if (clk_en)
			emitter_current_ua <= 19'(base_ua) * 19'(mag);
	end
endmodule

/* light_prox_properties.sv */
`timescale 1ns/1ps
module light_prox_properties #(
	parameter int PULSE_BASE_CYCLES = 4
) (
	input wire logic core_clk, // clock
	input wire logic reset, // async reset
	input wire logic emitter_fire, // pulse request
	input wire logic emitter_on, // emitter active
	input wire logic offset_cal_start, // measurement start
	input wire logic offset_cal_done, // measurement done
	input wire logic [7:0] offset_cal_value, // measured offset
	input wire logic offset_wr_en, // offset write pulse
	input wire logic [7:0] offset_wr_addr, // offset address
	input wire logic [7:0] offset_wr_data, // offset value
	input wire logic prox_enable, // proximity enabled
	input wire logic light_valid, // light result pulse
	input wire logic light_int, // light interrupt
	input wire logic prox_valid, // prox result pulse
	input wire logic prox_int // prox interrupt
);
	logic [15:0] run_len;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);
	// length of the current emitter pulse
	always_ff @(posedge core_clk or posedge reset)
	begin
		if (reset)
			run_len <= 16'h0000;
		else if (emitter_on)
			run_len <= run_len + 16'h0001;
		else
			run_len <= 16'h0000;
	end
	a_emit_cause: assert property ($rose(emitter_on) |-> $past(emitter_fire))
		else $error("emitter started without a request");
	a_emit_pulse_len: assert property ($fell(emitter_on) |-> (run_len % PULSE_BASE_CYCLES == 0)
		&& $onehot(run_len / PULSE_BASE_CYCLES) && (run_len <= 128 * PULSE_BASE_CYCLES))
		else $error("emitter pulse length not a power-of-two multiple");
	a_cal_start_gate: assert property ($rose(offset_cal_start) |-> $past(prox_enable))
		else $error("offset measurement started while proximity disabled");
	a_cal_wr_cause: assert property (offset_wr_en |-> $past(offset_cal_done))
		else $error("offset write without finished measurement");
	a_cal_wr_addr: assert property (offset_wr_en |-> offset_wr_addr == 8'hA5)
		else $error("offset write to wrong address");
	a_cal_wr_data: assert property (offset_wr_en |-> offset_wr_data == $past(offset_cal_value))
		else $error("offset write carries wrong value");
	a_light_int_src: assert property ($rose(light_int) |-> $past(light_valid))
		else $error("light interrupt without new result");
	a_prox_int_src: assert property ($rose(prox_int) |-> $past(prox_valid))
		else $error("prox interrupt without new result");
	c_light_int: cover property ($rose(light_int));
	c_offset_wr: cover property (offset_wr_en);
	c_emit_end: cover property ($fell(emitter_on));
endmodule

/* i2c_host_model.sv */
`timescale 1ns/1ps
module i2c_host_model #(
	parameter logic [6:0] DEV = 7'h38 // arbitrary
) (
	output logic scl, // serial clock, idle high
	output logic sda, // resolved data wire
	input wire logic sda_oe_n // device pulls low when 0
);
	logic drv;
	logic nak_seen;
	// open-drain wire with pull-up
	assign sda = drv & sda_oe_n;
	initial
	begin
		scl = 1'b1;
		drv = 1'b1;
		nak_seen = 1'b0;
	end
	// one bit: data set while clock low, sampled at end of high
	task automatic bit_x(input logic b, output logic r);
		drv = b;
		#100 scl = 1'b1;
		#100 r = sda;
		scl = 1'b0;
		#40;
	endtask
	task automatic start();
		drv = 1'b1;
		#100 scl = 1'b1;
		#100 drv = 1'b0;
		#100 scl = 1'b0;
		#40;
	endtask
	task automatic stop();
		drv = 1'b0;
		#100 scl = 1'b1;
		#100 drv = 1'b1;
		#100;
	endtask
	task automatic put(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--)
			bit_x(d[i], r);
		bit_x(1'b1, r);
		if (r !== 1'b0)
			nak_seen = 1'b1;
	endtask
	// pointer write then data bytes, pointer advances per byte
	task automatic wr(input logic [7:0] ptr, input logic [7:0] q[$]);
		start();
		put({DEV, 1'b0});
		put(ptr);
		foreach (q[i])
			put(q[i]);
		stop();
	endtask
	// pointer write, repeated start, n bytes, nack on last
	task automatic rd(input logic [7:0] ptr, input int n, output logic [7:0] q[$]);
		logic [7:0] d;
		logic r;
		q = {};
		start();
		put({DEV, 1'b0});
		put(ptr);
		start();
		put({DEV, 1'b1});
		for (int k = 0; k < n; k++)
		begin
			for (int i = 7; i >= 0; i--)
				bit_x(1'b1, d[i]);
			bit_x(k == n - 1, r);
			q.push_back(d);
		end
		stop();
	endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic core_clk = 0, reset = 1, scl, sda, sda_out, sda_oe_n, auto_scale = 0, light_valid = 0, light_int;
	logic light_int_clear = 0, prox_enable = 0, prox_valid = 0, prox_int, prox_int_clear = 0, offset_cal_start;
	logic offset_cal_done = 0, offset_wr_en, emitter_fire = 0, emitter_on;
	logic [1:0] light_persist = 0;
	logic [15:0] light_data = 0;
	logic [7:0] prox_data = 0, offset_cal_value = 0, offset_wr_addr, offset_wr_data, q[$];
	logic [3:0] drive_magnify = 0;
	logic [18:0] emitter_current_ua;
	int bad_count = 0, n_compared = 0, cycles = 0, cs_count = 0, n;
	always #2.5 core_clk = ~core_clk;
	light_prox_threshold_regs #(.PULSE_BASE_CYCLES(4)) u_dut (.core_clk(core_clk), .reset(reset), .clk_en(1'b1),
		.scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .auto_scale(auto_scale),
		.light_persist(light_persist), .light_valid(light_valid), .light_data(light_data), .light_int(light_int),
		.light_int_clear(light_int_clear), .prox_enable(prox_enable), .prox_valid(prox_valid),
		.prox_data(prox_data), .prox_high_limit(8'h80), .prox_low_limit(8'h20), .prox_int(prox_int),
		.prox_int_clear(prox_int_clear), .offset_cal_start(offset_cal_start), .offset_cal_done(offset_cal_done),
		.offset_cal_value(offset_cal_value), .offset_wr_en(offset_wr_en), .offset_wr_addr(offset_wr_addr),
		.offset_wr_data(offset_wr_data), .emitter_fire(emitter_fire), .emitter_on(emitter_on),
		.drive_magnify(drive_magnify), .emitter_current_ua(emitter_current_ua));
	i2c_host_model u_host (.scl(scl), .sda(sda), .sda_oe_n(sda_oe_n));
	// timeout and measurement-start counting
	always @(posedge core_clk)
	begin
		cycles++;
		cs_count += offset_cal_start;
		if (cycles == 90000)
		begin
			bad_count++;
			results();
		end
	end
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			$display("BAD %s expected %h seen %h", nm, exp, seen);
			bad_count++;
		end
	endtask
	task automatic tick();
		@(posedge core_clk);
		#1;
	endtask
	// one light result followed by settling cycles
	task automatic lv(input logic [15:0] d);
		light_valid = 1;
		light_data = d;
		tick();
		light_valid = 0;
		repeat (3) tick();
	endtask
	task automatic pv(input logic [7:0] d);
		prox_valid = 1;
		prox_data = d;
		tick();
		prox_valid = 0;
		repeat (3) tick();
	endtask
	task automatic t_regs();
		u_host.rd(8'h09, 1, q);
		chk("ctrl reset", q[0], 8'h00);
		u_host.rd(8'h05, 4, q);
		chk("limits reset", {q[3], q[2], q[1], q[0]}, 32'h0000FFFF);
		u_host.rd(8'h20, 1, q);
		chk("unmapped", q[0], 8'h00);
		u_host.wr(8'h03, '{8'hAA});
		u_host.wr(8'h05, '{8'h34, 8'h12, 8'h00, 8'h01});
		u_host.rd(8'h03, 6, q);
		chk("result ro", q[0], 8'h00);
		chk("limits rw", {q[5], q[4], q[3], q[2]}, 32'h01001234);
	endtask
	task automatic t_light();
		for (int c = 0; c < 4; c++)
		begin
			light_persist = c;
			lv(16'h0800);
			for (int i = 1; i < (1 << c); i++)
				lv(16'h2100);
			chk("light int early", light_int, 1'b0);
			lv(16'h2100);
			chk("light int high", light_int, 1'b1);
			light_int_clear = 1;
			tick();
			light_int_clear = 0;
		end
		u_host.rd(8'h03, 2, q);
		chk("auto result", {q[1], q[0]}, 16'h2100);
		light_persist = 0;
		lv(16'h00FF);
		chk("light int low", light_int, 1'b1);
		light_int_clear = 1;
		tick();
		light_int_clear = 0;
		auto_scale = 1;
		lv(16'hF123);
		chk("manual no int", light_int, 1'b0);
		u_host.rd(8'h03, 2, q);
		chk("manual result", {q[1], q[0]}, 16'h0123);
		// trigger and clear in one cycle: the trigger wins
		light_int_clear = 1;
		light_valid = 1;
		light_data = 16'h0FFF;
		tick();
		light_valid = 0;
		light_int_clear = 0;
		chk("set beats clear", light_int, 1'b1);
		light_int_clear = 1;
		tick();
		light_int_clear = 0;
		chk("int cleared", light_int, 1'b0);
	endtask
	task automatic t_prox();
		for (int c = 0; c < 4; c++)
		begin
			u_host.wr(8'h09, '{c[7:0]});
			pv(8'h50);
			for (int i = 0; i < c; i++)
				pv(8'h90);
			chk("prox int early", prox_int, 1'b0);
			pv(8'h90);
			chk("prox int", prox_int, 1'b1);
			prox_int_clear = 1;
			tick();
			prox_int_clear = 0;
		end
	endtask
	task automatic t_cal();
		prox_enable = 0;
		cs_count = 0;
		u_host.wr(8'h09, '{8'h80});
		repeat (20) tick();
		chk("cal gated", cs_count, 0);
		prox_enable = 1;
		repeat (20) tick();
		chk("cal start", cs_count, 1);
		offset_cal_done = 1;
		offset_cal_value = 8'h3C;
		tick();
		offset_cal_done = 0;
		chk("offset write", {offset_wr_en, offset_wr_addr, offset_wr_data}, 17'h1A53C);
		u_host.rd(8'h09, 1, q);
		chk("cal bit clear", q[0], 8'h00);
	endtask
	task automatic t_emit();
		int base[4] = '{2500, 5000, 10000, 15000};
		int mul[4] = '{1, 2, 10, 20};
		logic [3:0] mag[4] = '{4'h0, 4'h8, 4'h5, 4'hD};
		for (int c = 0; c < 8; c++)
		begin
			u_host.wr(8'h09, '{{1'b0, c[2:0], c[1:0], 2'b00}});
			drive_magnify = mag[c % 4];
			emitter_fire = 1;
			tick();
			emitter_fire = 0;
			n = 0;
			while (emitter_on === 1'b1 && n < 1000)
			begin
				tick();
				n++;
			end
			chk("pulse length", n, 4 << c);
			chk("drive current", emitter_current_ua, base[c % 4] * mul[c % 4]);
		end
	endtask
	initial
	begin
		repeat (12) tick();
		reset = 0;
		repeat (10) tick();
		u_host.wr(8'hA5, '{8'h1C});
		t_regs();
		t_light();
		t_prox();
		t_cal();
		t_emit();
		chk("all bytes acked", u_host.nak_seen, 1'b0);
		chk("sda drive value", sda_out, 1'b0);
		results();
	end
endmodule

bind light_prox_threshold_regs light_prox_properties #(.PULSE_BASE_CYCLES(PULSE_BASE_CYCLES)) u_props (
	.core_clk, .reset, .emitter_fire, .emitter_on, .offset_cal_start, .offset_cal_done, .offset_cal_value,
	.offset_wr_en, .offset_wr_addr, .offset_wr_data, .prox_enable, .light_valid, .light_int, .prox_valid,
	.prox_int);
